// >>> core/dcdp_pkg.sv
// Purpose: Constants for the converter drive and protection block
// Assumes: One 10 MHz clock, all inputs synchronous to it
// Notes:   Comparator results and sync pulses arrive as digital levels
//
// How it works
// - Phase 0: set after flyback-middle delay
// - Phase 1, edge 0: set on falling line
// - Phase 1, edge 1: set on rising line
// - Drive turns on after one-shot ends
// - Current limit comparator resets drive
// - Error level comparator also resets, OR-ed
// - Polarity bit inverts drive output
// - Current limit threshold follows soft ramp
// - Line on first, converter off first
// - Same sequence for every switching cause
// - Overvoltage kills drives after two lines
// - Overvoltage latch held until supply/clear
// - Lock and blank give four levels
// - Blank combines vsync and discharge pulse
// - Blank starts first edge, ends discharge
// - Hold select forces permanent blank level
// - Low supply, overvoltage, vdrive off force blank
// - Line enable toggle starts soft ramp
package dcdp_pkg;
    // =========================================================
    // Timing
    localparam int  CLK_PERIOD_NS     = 100;
    localparam int  ONESHOT_NS        = 200;
    localparam int  ONESHOT_CYC       =
        (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  TRIG_DELAY_DEF    = 4;
    localparam int  RAMP_STEP_NS      = 1000;
    localparam int  RAMP_STEP_CYC     =
        (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  OV_LINES          = 2;
    // =========================================================
    // Ramp levels and composite output codes
    localparam logic [7:0] RAMP_ZERO  = 8'h00;
    localparam logic [7:0] RAMP_FULL  = 8'hFF;
    localparam logic [7:0] RAMP_HALF  = 8'h80;
    localparam logic [1:0] LVL_UNLK_NOBLK = 2'h0;
    localparam logic [1:0] LVL_LOCK_NOBLK = 2'h1;
    localparam logic [1:0] LVL_UNLK_BLK   = 2'h2;
    localparam logic [1:0] LVL_LOCK_BLK   = 2'h3;
    // =========================================================
    // Register map (word addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_DELAY  = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_RAMP   = 4'h3;
    // Control bit positions
    localparam int  B_PHASE   = 0;
    localparam int  B_EDGE    = 1;
    localparam int  B_POL     = 2;
    localparam int  B_LINE_EN = 3;
    localparam int  B_VDRV_EN = 4;
    localparam int  B_HOLD    = 5;
    localparam int  B_OV_CLR  = 6;
    localparam logic [7:0] CTRL_RESET = 8'h30; // Hold and vdrive on
    // Sequencer states
    typedef enum logic [4:0] {
        SEQ_OFF     = 5'h01,
        SEQ_LINE_UP = 5'h02,
        SEQ_CONV_UP = 5'h04,
        SEQ_RUN     = 5'h08,
        SEQ_DOWN    = 5'h10
    } dcdp_seq_type;
endpackage

// >>> core/dcdp_oneshot.sv
// Purpose: Retriggerable one-shot that reports its own end
// Assumes: Trigger is a one-cycle pulse
// Notes:   done pulses for one cycle, starting on the clock where busy falls
module dcdp_oneshot #(
    parameter int LEN = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // Trigger and end
    input  wire logic trig,
    output logic      busy,
    output logic      done
);
    // Refuse lengths the 8-bit counter cannot hold
    if (LEN < 1 || LEN > 255) begin : g_bad_len
        $error("dcdp_oneshot: bad LEN");
    end
    logic [7:0] cnt_q;
    // =========================================================
    // Count down, flag the last cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 8'h00;
            done  <= 1'b0;
        end else if (clk_en) begin
            done <= (cnt_q == 8'h01) && !trig;
            if (trig) begin
                cnt_q <= 8'(LEN);
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
    assign busy = (cnt_q != 8'h00);
endmodule // dcdp_oneshot

// >>> core/dcdp_core.sv
// Purpose: Converter drive pulse, soft sequencing, overvoltage, blanking
// Assumes: Comparator results are already digital levels
// Notes:   Ramp counter stands in for the analog soft-start node
module dcdp_core #(
    parameter int TRIG_DELAY = dcdp_pkg::TRIG_DELAY_DEF
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Timing references
    input  wire logic       flyback_mid,
    input  wire logic       line_ref,
    input  wire logic       line_pulse,
    input  wire logic       vsync_in,
    input  wire logic       vdischarge_in,
    input  wire logic       pll_locked,
    input  wire logic       supply_ok,
    // Comparator inputs
    input  wire logic       current_sense_in,
    input  wire logic       error_sense_in,
    input  wire logic       overvoltage_sense_in,
    // Outputs
    output logic            line_drive_out,
    output logic            converter_drive_out,
    output logic [1:0]      lock_blank_composite_out,
    output logic [7:0]      current_limit_threshold
);
    // Refuse delays the 8-bit counter cannot hold
    if (TRIG_DELAY < 1 || TRIG_DELAY > 255) begin : g_bad_delay
        $error("dcdp_core: bad TRIG_DELAY");
    end
    // =========================================================
    // Registers
    logic [7:0] ctrl_q;
    logic [7:0] flyback_trigger_delay;
    logic       ov_latch_q;
    logic       wr_ctrl;
    assign wr_ctrl = reg_wr && (reg_addr == dcdp_pkg::ADDR_CTRL);
    wire converter_phase_select   = ctrl_q[dcdp_pkg::B_PHASE];
    wire line_edge_select         = ctrl_q[dcdp_pkg::B_EDGE];
    wire converter_drive_polarity = ctrl_q[dcdp_pkg::B_POL];
    wire line_drive_enable        = ctrl_q[dcdp_pkg::B_LINE_EN];
    wire vertical_drive_enable    = ctrl_q[dcdp_pkg::B_VDRV_EN];
    wire blank_hold_select        = ctrl_q[dcdp_pkg::B_HOLD];
    wire overvoltage_latch_clear  =
        wr_ctrl && reg_wdata[dcdp_pkg::B_OV_CLR];
    dcdp_pkg::dcdp_seq_type state_q;
    logic [7:0] ramp_q;

    // Control writes; the clear bit is a self-clearing strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q                <= dcdp_pkg::CTRL_RESET;
            flyback_trigger_delay <= 8'(TRIG_DELAY);
        end else if (clk_en && reg_wr) begin
            if (reg_addr == dcdp_pkg::ADDR_CTRL)
                ctrl_q <= reg_wdata & ~(8'h01 << dcdp_pkg::B_OV_CLR);
            if (reg_addr == dcdp_pkg::ADDR_DELAY && reg_wdata != 8'h00)
                flyback_trigger_delay <= reg_wdata;
        end
    end

    // Read data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd) begin
                unique case (reg_addr)
                    dcdp_pkg::ADDR_CTRL:   reg_rdata <= ctrl_q;
                    dcdp_pkg::ADDR_DELAY:  reg_rdata <= flyback_trigger_delay;
                    dcdp_pkg::ADDR_STATUS: reg_rdata <= {3'h0, state_q};
                    dcdp_pkg::ADDR_RAMP:   reg_rdata <= ramp_q;
                    default:               reg_rdata <= {7'h00, ov_latch_q};
                endcase
                if (reg_addr > dcdp_pkg::ADDR_RAMP)
                    reg_rdata <= 8'h00;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
    // =========================================================
    // Overvoltage filter and latch
    logic [1:0] ov_lines_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ov_lines_q <= 2'h0;
        end else if (clk_en) begin
            if (!overvoltage_sense_in)
                ov_lines_q <= 2'h0;
            else if (line_pulse && ov_lines_q != 2'(dcdp_pkg::OV_LINES))
                ov_lines_q <= ov_lines_q + 2'h1;
        end
    end
    // Set wins over clear so a trip is never lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ov_latch_q <= 1'b0;
        end else if (clk_en) begin
            if (ov_lines_q == 2'(dcdp_pkg::OV_LINES))
                ov_latch_q <= 1'b1;
            else if (!supply_ok || overvoltage_latch_clear)
                ov_latch_q <= 1'b0;
        end
    end
    // =========================================================
    // Soft sequencer: one ramp serves all causes alike
    wire run_req = line_drive_enable && supply_ok && !ov_latch_q;
    logic [3:0] step_q;
    wire        step = (step_q == 4'(dcdp_pkg::RAMP_STEP_CYC - 1));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            step_q <= 4'h0;
        end else if (clk_en) begin
            step_q <= step ? 4'h0 : step_q + 4'h1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= dcdp_pkg::SEQ_OFF;
            ramp_q  <= dcdp_pkg::RAMP_ZERO;
        end else if (clk_en) begin
            unique case (state_q)
                dcdp_pkg::SEQ_OFF: begin
                    ramp_q <= dcdp_pkg::RAMP_ZERO;
                    if (run_req)
                        state_q <= dcdp_pkg::SEQ_LINE_UP;
                end
                // Line first, then converter once ramp is halfway
                dcdp_pkg::SEQ_LINE_UP: begin
                    if (!run_req)
                        state_q <= dcdp_pkg::SEQ_DOWN;
                    else if (step) begin
                        ramp_q <= ramp_q + 8'h01;
                        if (ramp_q == dcdp_pkg::RAMP_HALF)
                            state_q <= dcdp_pkg::SEQ_CONV_UP;
                    end
                end
                dcdp_pkg::SEQ_CONV_UP: begin
                    if (!run_req)
                        state_q <= dcdp_pkg::SEQ_DOWN;
                    else if (step) begin
                        ramp_q <= ramp_q + 8'h01;
                        if (ramp_q == dcdp_pkg::RAMP_FULL - 8'h01)
                            state_q <= dcdp_pkg::SEQ_RUN;
                    end
                end
                dcdp_pkg::SEQ_RUN: begin
                    if (!run_req)
                        state_q <= dcdp_pkg::SEQ_DOWN;
                end
                // Converter stops at half ramp, line last at zero
                dcdp_pkg::SEQ_DOWN: begin
                    if (step) begin
                        if (ramp_q <= 8'h01) begin
                            ramp_q  <= dcdp_pkg::RAMP_ZERO;
                            state_q <= dcdp_pkg::SEQ_OFF;
                        end else begin
                            ramp_q <= ramp_q - 8'h01;
                        end
                    end
                end
                default: state_q <= dcdp_pkg::SEQ_OFF;
            endcase
        end
    end
    wire line_on = (state_q != dcdp_pkg::SEQ_OFF);
    wire conv_on = (state_q == dcdp_pkg::SEQ_CONV_UP)
                || (state_q == dcdp_pkg::SEQ_RUN)
                || (state_q == dcdp_pkg::SEQ_DOWN
                    && ramp_q > dcdp_pkg::RAMP_HALF);
    // =========================================================
    // Trigger selection
    logic line_ref_q;
    logic [7:0] dly_q;
    logic       fly_trig;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_ref_q <= 1'b0;
            dly_q      <= 8'h00;
            fly_trig   <= 1'b0;
        end else if (clk_en) begin
            line_ref_q <= line_ref;
            fly_trig   <= (dly_q == 8'h01);
            if (flyback_mid)
                dly_q <= flyback_trigger_delay;
            else if (dly_q != 8'h00)
                dly_q <= dly_q - 8'h01;
        end
    end
    wire rise = line_ref && !line_ref_q;
    wire fall = !line_ref && line_ref_q;
    wire trig = !converter_phase_select ? fly_trig
              : line_edge_select        ? rise
              :                           fall;
    logic os_busy;
    logic os_done;
    dcdp_oneshot #(.LEN(dcdp_pkg::ONESHOT_CYC)) u_oneshot (
        .clk   (clk),
        .reset (reset),
        .clk_en(clk_en),
        .trig  (trig && conv_on),
        .busy  (os_busy),
        .done  (os_done)
    );
    // =========================================================
    // Drive flip-flop, reset conditions dominate
    logic drive_q;
    wire  reset_cond = current_sense_in
                    || error_sense_in;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_q <= 1'b0;
        end else if (clk_en) begin
            if (reset_cond || !conv_on)
                drive_q <= 1'b0;
            else if (os_done)
                drive_q <= 1'b1;
        end
    end
    // =========================================================
    // Blanking and composite output
    logic blank_q;
    logic vdis_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blank_q <= 1'b0;
            vdis_q  <= 1'b0;
        end else if (clk_en) begin
            vdis_q <= vdischarge_in;
            if (vsync_in || vdischarge_in)
                blank_q <= 1'b1;
            else if (vdis_q)
                blank_q <= 1'b0;
        end
    end
    wire blank_now = blank_q || vsync_in || vdischarge_in
                  || blank_hold_select
                  || !supply_ok || ov_latch_q
                  || !vertical_drive_enable;
    // All outputs registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_drive_out           <= 1'b0;
            converter_drive_out      <= 1'b0;
            lock_blank_composite_out <= dcdp_pkg::LVL_UNLK_BLK;
            current_limit_threshold  <= dcdp_pkg::RAMP_ZERO;
        end else if (clk_en) begin
            line_drive_out      <= line_on && line_ref;
            // Polarity applied last so the pin follows the bit on the next clock
            converter_drive_out <= drive_q
                                 ^ converter_drive_polarity;
            current_limit_threshold <= ramp_q;
            unique case ({blank_now, pll_locked})
                2'b00: lock_blank_composite_out <= dcdp_pkg::LVL_UNLK_NOBLK;
                2'b01: lock_blank_composite_out <= dcdp_pkg::LVL_LOCK_NOBLK;
                2'b10: lock_blank_composite_out <= dcdp_pkg::LVL_UNLK_BLK;
                2'b11: lock_blank_composite_out <= dcdp_pkg::LVL_LOCK_BLK;
            endcase
        end
    end
    // =========================================================
    // Checks
    // A trip sends the sequencer down; the converter fades, not cut
    property p_ov_kill;
        @(posedge clk) disable iff (reset)
        clk_en && ov_latch_q |=> (state_q == dcdp_pkg::SEQ_DOWN)
                              || (state_q == dcdp_pkg::SEQ_OFF);
    endproperty
    a_ov_kill: assert property (p_ov_kill)
        else $error("ov no kill");
    property p_ov_delay;
        @(posedge clk) disable iff (reset)
        $rose(ov_latch_q) |-> $past(ov_lines_q) == 2'(dcdp_pkg::OV_LINES);
    endproperty
    a_ov_delay: assert property (p_ov_delay)
        else $error("ov latched early");
    property p_ov_clear;
        @(posedge clk) disable iff (reset)
        clk_en && overvoltage_latch_clear
            && ov_lines_q != 2'(dcdp_pkg::OV_LINES) |=> !ov_latch_q;
    endproperty
    a_ov_clear: assert property (p_ov_clear)
        else $error("ov clear lost");
    property p_conv_needs_line;
        @(posedge clk) disable iff (reset)
        conv_on |-> line_on;
    endproperty
    a_conv_needs_line: assert property (p_conv_needs_line)
        else $error("conv without line");
    property p_line_first;
        @(posedge clk) disable iff (reset)
        clk_en && !line_on |=> !conv_on;
    endproperty
    a_line_first: assert property (p_line_first)
        else $error("conv before line");
    property p_reset_wins;
        @(posedge clk) disable iff (reset)
        clk_en && reset_cond |=> !drive_q;
    endproperty
    a_reset_wins: assert property (p_reset_wins)
        else $error("no reset");
    property p_pol;
        @(posedge clk) disable iff (reset)
        clk_en |=> converter_drive_out
                   == ($past(drive_q) ^ $past(converter_drive_polarity));
    endproperty
    a_pol: assert property (p_pol)
        else $error("polarity");
    property p_set_after_shot;
        @(posedge clk) disable iff (reset)
        $rose(drive_q) |-> $past(os_done);
    endproperty
    a_set_after_shot: assert property (p_set_after_shot)
        else $error("set w/o shot");
    property p_hold_blank;
        @(posedge clk) disable iff (reset)
        clk_en && blank_hold_select |=> lock_blank_composite_out[1];
    endproperty
    a_hold_blank: assert property (p_hold_blank)
        else $error("blank");
    property p_ov_force_blank;
        @(posedge clk) disable iff (reset)
        clk_en && ov_latch_q |=> lock_blank_composite_out[1];
    endproperty
    a_ov_force_blank: assert property (p_ov_force_blank)
        else $error("ov blank");
    property p_blank_start;
        @(posedge clk) disable iff (reset)
        clk_en && (vsync_in || vdischarge_in) |=> lock_blank_composite_out[1];
    endproperty
    a_blank_start: assert property (p_blank_start)
        else $error("blank start");
    property p_lock_level;
        @(posedge clk) disable iff (reset)
        clk_en |=> lock_blank_composite_out[0] == $past(pll_locked);
    endproperty
    a_lock_level: assert property (p_lock_level)
        else $error("lock level");
    property p_thr;
        @(posedge clk) disable iff (reset)
        clk_en |=> current_limit_threshold == $past(ramp_q);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold");
    c_run: cover property (@(posedge clk) state_q == dcdp_pkg::SEQ_RUN);
    c_shot: cover property (@(posedge clk) $fell(os_busy));
    c_trip: cover property (@(posedge clk) $rose(ov_latch_q));
    c_drive: cover property (@(posedge clk) $rose(drive_q));
endmodule // dcdp_core

// >>> testbench/dcdp_switch_model.sv
// Purpose: Power switch and feedback network seen by the drive pin
// Assumes: The board inverts the switch when the pin is active low
// Notes:   Comparator trips are counts of on-cycles, not voltages
module dcdp_switch_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Drive pin and board polarity
    input  wire logic       drive,
    input  wire logic       active_low,
    // Trip points in on-cycles
    input  wire logic [5:0] cur_lim,
    input  wire logic [5:0] err_lim,
    // Comparator levels back to the block
    output logic            current_sense_in,
    output logic            error_sense_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================
    // Switch current grows while conducting, resets when open
    logic [5:0] on_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            on_q <= 6'h00;
        end else if (drive ^ active_low) begin
            on_q <= (on_q == 6'h3F) ? on_q : on_q + 6'h01;
        end else begin
            on_q <= 6'h00;
        end
    end
    // Trips drop on the clock after the switch opens, no hold time
    assign current_sense_in = (on_q >= cur_lim);
    assign error_sense_in   = (on_q >= err_lim);
endmodule // dcdp_switch_model

// >>> testbench/dcdp_core_test.sv
// Purpose: Self-checking bench for the converter drive block
// Assumes: Lines of 40 cycles, line reference high for the first 20
// Notes:   Drive timing is judged by positions within a line
module dcdp_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================
    // Signals
    logic       clk, reset, reg_wr, reg_rd, pll_locked, supply_ok;
    logic       vsync_in, vdischarge_in, ov_in, pol, ce;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, thr;
    logic [5:0] pos_q, cur_lim, err_lim, rise_pos, width;
    logic       line_drive_out, converter_drive_out, act_q, cs, es;
    logic [1:0] comp;
    int         error_cnt, tests_run, cyc, lr_last, bad_seq, wcnt;
    int         p[5];
    logic [7:0] tc[5];
    logic [7:0] td[5];
    logic [7:0] v, ta, w_a, w_b;
    wire        act = converter_drive_out ^ pol;
    wire        line_ref = pos_q < 6'd20;

    dcdp_core #(.TRIG_DELAY(4)) uut (
        .clk(clk), .reset(reset), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flyback_mid(pos_q == 6'd30), .line_ref(line_ref),
        .line_pulse(pos_q == 6'd0), .vsync_in(vsync_in),
        .vdischarge_in(vdischarge_in), .pll_locked(pll_locked),
        .supply_ok(supply_ok), .current_sense_in(cs),
        .error_sense_in(es), .overvoltage_sense_in(ov_in),
        .line_drive_out(line_drive_out),
        .converter_drive_out(converter_drive_out),
        .lock_blank_composite_out(comp),
        .current_limit_threshold(thr));

    dcdp_switch_model sw (
        .clk(clk), .reset(reset), .drive(converter_drive_out),
        .active_low(pol), .cur_lim(cur_lim), .err_lim(err_lim),
        .current_sense_in(cs), .error_sense_in(es));

    // ========================================================
    // Clock, line timing and drive monitor
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // Converter active while line drive silent a whole line is a fault
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_q <= 6'd0;
            cyc <= 0;
            lr_last <= 0;
            act_q <= 1'b0;
        end else begin
            pos_q <= (pos_q == 6'd39) ? 6'd0 : pos_q + 6'd1;
            cyc <= cyc + 1;
            act_q <= act;
            wcnt <= act ? wcnt + 1 : 0;
            if (line_drive_out === 1'b1) lr_last <= cyc;
            if (act === 1'b1 && cyc - lr_last > 45) bad_seq <= bad_seq + 1;
            if (act && !act_q) rise_pos <= pos_q;
            if (!act && act_q) width <= 6'(wcnt);
        end
    end

    // ========================================================
    // Bus and checking tasks
    task automatic chk(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk("register", d, e);
    endtask
    task automatic wait_st(input logic [7:0] e);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 1500 && d !== e; i++) rd(4'h2, d);
        chk("status", d, e);
    endtask
    task automatic at_pos(input logic [5:0] q);
        while (pos_q !== q) @(posedge clk);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog sized well past the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        give_verdict;
    end

    // ========================================================
    // Main sequence
    initial begin
        {reset, reg_wr, reg_rd, pll_locked, vsync_in} = 5'b10000;
        {vdischarge_in, ov_in, pol, supply_ok, ce} = 5'b00011;
        {reg_addr, reg_wdata, wcnt, bad_seq} = '0;
        {cur_lim, err_lim} = {6'd6, 6'd20};
        tc = '{8'h3B, 8'h39, 8'h38, 8'h3A, 8'h38};
        td = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h09};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rchk(4'h0, 8'h30);
        rchk(4'h1, 8'h04);
        rchk(4'h2, 8'h01);
        rchk(4'hF, 8'h00);
        chk("composite", {6'h00, comp}, 8'h02);
        pll_locked <= 1'b1;
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h03);
        // Soft start: threshold climbs, then run
        wr(4'h0, 8'h38);
        repeat (600) @(posedge clk);
        // Enable low must freeze the ramp mid-climb
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ta = thr;
        repeat (30) @(posedge clk);
        chk("freeze", thr, ta);
        ce <= 1'b1;
        repeat (600) @(posedge clk);
        chk("ramp", {7'h00, thr > ta}, 8'h01);
        wait_st(8'h08);
        chk("threshold", thr, dcdp_pkg::RAMP_FULL);
        // Trigger source table
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, tc[i]);
            wr(4'h1, td[i]);
            repeat (120) @(posedge clk);
            p[i] = rise_pos;
        end
        rchk(4'h1, 8'h09);
        chk("fall", 8'((p[1] - p[0] + 40) % 40), 8'h14);
        chk("edge", 8'(p[3]), 8'(p[2]));
        chk("delay", 8'((p[4] - p[2] + 40) % 40), 8'h05);
        chk("oneshot", {7'h00, p[0] >= dcdp_pkg::ONESHOT_CYC
            && p[0] <= dcdp_pkg::ONESHOT_CYC + 6}, 8'h01);
        chk("flyback", {7'h00, (p[2] + 6) % 40 >= dcdp_pkg::ONESHOT_CYC
            && (p[2] + 6) % 40 <= dcdp_pkg::ONESHOT_CYC + 6}, 8'h01);
        wr(4'h1, 8'h04);
        wr(4'h0, 8'h3B);
        repeat (120) @(posedge clk);
        w_a = {2'b00, width};
        {cur_lim, err_lim} <= {6'd20, 6'd3};
        repeat (120) @(posedge clk);
        w_b = {2'b00, width};
        chk("error trip", w_a - w_b, 8'h03);
        {cur_lim, err_lim} <= {6'd6, 6'd20};
        // Inverted pin gives the same pulse
        wr(4'h0, 8'h3F);
        pol <= 1'b1;
        repeat (120) @(posedge clk);
        chk("polarity width", {2'b00, width}, w_a);
        chk("polarity pos", {2'b00, rise_pos}, 8'(p[0]));
        wr(4'h0, 8'h1B);
        pol <= 1'b0;
        // Blanking from vsync and discharge with hold off
        repeat (80) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h01);
        vsync_in <= 1'b1;
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h03);
        {vsync_in, vdischarge_in} <= 2'b01;
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h03);
        vdischarge_in <= 1'b0;
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h01);
        pll_locked <= 1'b0;
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h00);
        pll_locked <= 1'b1;
        wr(4'h0, 8'h0B);
        repeat (4) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h03);
        wr(4'h0, 8'h1B);
        // Overvoltage spike over one line, then a real trip
        at_pos(6'd10);
        ov_in <= 1'b1;
        repeat (40) @(posedge clk);
        ov_in <= 1'b0;
        repeat (80) @(posedge clk);
        at_pos(6'd10);
        ov_in <= 1'b1;
        repeat (50) @(posedge clk);
        rchk(4'h2, 8'h08);
        repeat (40) @(posedge clk);
        rchk(4'h2, 8'h10);
        chk("composite", {6'h00, comp}, 8'h03);
        ov_in <= 1'b0;
        wait_st(8'h01);
        repeat (200) @(posedge clk);
        rchk(4'h2, 8'h01);
        chk("line", {7'h00, line_drive_out}, 8'h00);
        wr(4'h0, 8'h5B);
        wait_st(8'h08);
        // Software off, then supply loss
        wr(4'h0, 8'h13);
        wait_st(8'h10);
        wait_st(8'h01);
        chk("line", {7'h00, line_drive_out}, 8'h00);
        wr(4'h0, 8'h1B);
        wait_st(8'h08);
        supply_ok <= 1'b0;
        repeat (5) @(posedge clk);
        chk("composite", {6'h00, comp}, 8'h03);
        wait_st(8'h10);
        chk("order", 8'(bad_seq), 8'h00);
        give_verdict;
    end
endmodule // dcdp_core_test
